//--- sim/iena_ptp_framer_chk.sv
// Concurrent checks on the framer's packet stream and delay request stream.
`timescale 1ns/1ps
module iena_ptp_framer_chk (
	input wire logic              mclk,
	input wire logic              arst_n,
	input wire iena_pkg::sample_t sampleIn,
	input wire logic              sampleReady,
	input wire iena_pkg::word16_t udpOut,
	input wire logic              udpReady,
	input wire iena_pkg::word16_t ptpTx,
	input wire logic              ptpTxReady
);
	// ----------
	// Word position trackers
	// ----------
	logic [15:0] wordCnt_q;
	logic [15:0] size_q;
	logic [2:0]  txIdx_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wordCnt_q <= 16'h0;
		end else if (udpOut.valid && udpReady) begin
			wordCnt_q <= udpOut.last ? 16'h0 : wordCnt_q + 16'h1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			size_q <= 16'h0;
		end else if (udpOut.valid && udpReady && wordCnt_q == 16'h1) begin
			size_q <= udpOut.word;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txIdx_q <= 3'h0;
		end else if (ptpTx.valid && ptpTxReady) begin
			txIdx_q <= ptpTx.last ? 3'h0 : txIdx_q + 3'h1;
		end
	end

	// ----------
	// Properties
	// ----------
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_udp_hold: assert property (udpOut.valid && !udpReady |=> udpOut.valid && $stable(udpOut))
		else $error("packet word changed while stalled");
	a_trail_gap: assert property (udpOut.valid && udpReady && udpOut.last |=> !udpOut.valid)
		else $error("no idle cycle after trailer");
	a_status_zero: assert property (udpOut.valid && wordCnt_q == 16'h5 |-> udpOut.word == 16'h0)
		else $error("status word not zero");
	a_size_count: assert property (udpOut.valid && udpOut.last |-> wordCnt_q == size_q + 16'h7)
		else $error("trailer position disagrees with size");
	a_take_data: assert property (sampleReady |=> udpOut.valid && udpOut.word == $past(sampleIn.word))
		else $error("taken sample not emitted next");
	a_ready_valid: assert property (sampleReady |-> sampleIn.valid)
		else $error("sample taken without valid");
	a_tx_hold: assert property (ptpTx.valid && !ptpTxReady |=> ptpTx.valid && $stable(ptpTx))
		else $error("request word changed while stalled");
	a_tx_head: assert property (ptpTx.valid && txIdx_q == 3'h0 |-> ptpTx.word == 16'h0101)
		else $error("request header word wrong");
	a_tx_length: assert property (ptpTx.valid && ptpTx.last |-> txIdx_q == 3'h6)
		else $error("request length wrong");
endmodule : iena_ptp_framer_chk

bind iena_ptp_framer iena_ptp_framer_chk chk_u (.mclk, .arst_n, .sampleIn, .sampleReady,
	.udpOut, .udpReady, .ptpTx, .ptpTxReady);

//--- sim/ptp_master_model.sv
// Grandmaster model: takes delay requests and sends timing messages.
`timescale 1ns/1ps
module ptp_master_model #(
	parameter logic [47:0] PATH_US = 48'd40
) (
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire iena_pkg::word16_t ptpTx,
	output logic                   ptpTxReady,
	output iena_pkg::ptp_rx_t      ptpRx
);
	logic [15:0] reqWord [0:6];
	logic [2:0]  reqIdx;
	logic [1:0]  stallCnt;
	logic        reqDone;

	// Refusing one cycle in three forces the sender to hold its word.
	assign ptpTxReady = (stallCnt != 2'h0);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reqIdx   <= 3'h0;
			reqDone  <= 1'b0;
			stallCnt <= 2'h0;
		end else begin
			stallCnt <= (stallCnt == 2'h2) ? 2'h0 : stallCnt + 2'h1;
			if (ptpTx.valid && ptpTxReady) begin
				reqWord[reqIdx] <= ptpTx.word;
				reqIdx          <= ptpTx.last ? 3'h0 : reqIdx + 3'h1;
				reqDone         <= ptpTx.last;
			end
		end
	end

	initial ptpRx = '0;

	// One-cycle message; afterwards the fields show inverted garbage, not the old value.
	task automatic send(input logic [7:0] typ, input logic [7:0] ctl, input logic [15:0] seq,
			input logic [31:0] rsvd, input logic [47:0] ts);
		iena_pkg::ptp_rx_t m;
		m = '{1'b1, typ, ctl, seq, rsvd, ts};
		@(posedge mclk);
		ptpRx <= m;
		@(posedge mclk);
		ptpRx <= {1'b0, ~m[$bits(m)-2:0]};
	endtask : send

	// Arrival stamp is departure stamp plus a fixed path delay.
	task automatic answer();
		send(iena_pkg::MSG_GENERAL, iena_pkg::CTL_DRESP, reqWord[1], 32'h0,
			{reqWord[4], reqWord[5], reqWord[6]} + PATH_US);
	endtask : answer
endmodule : ptp_master_model

//--- sim/tb_top.sv
// Self-checking bench for the telemetry framer and time slave.
`timescale 1ns/1ps
module tb_top;
	logic              mclk;
	logic              arst_n;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic              hready;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	iena_pkg::sample_t sampleIn;
	logic              sampleReady;
	iena_pkg::word16_t udpOut;
	logic              udpReady;
	iena_pkg::ptp_rx_t ptpRx;
	iena_pkg::word16_t ptpTx;
	logic              ptpTxReady;
	logic [31:0]       rdSample;
	int                numErrors;
	int                samplesChecked;

	assign hready = hreadyout;

	iena_ptp_framer dut_u (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .sampleIn, .sampleReady, .udpOut, .udpReady,
		.ptpRx, .ptpTx, .ptpTxReady);

	ptp_master_model gm_u (.mclk, .arst_n, .ptpTx, .ptpTxReady, .ptpRx);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ----------
	// Tasks
	// ----------
	task automatic reportAndStop();
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : reportAndStop

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic failWait();
		numErrors++;
		reportAndStop();
	endtask : failWait

	task automatic waitReady();
		logic ok;
		ok = 1'b0;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge mclk);
			ok = hready;
			rdSample = hrdata;
		end
		if (!ok) failWait();
	endtask : waitReady

	task automatic busCycle(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		waitReady();
	endtask : busCycle

	task automatic busRd(input logic [7:0] a, output logic [31:0] d);
		busCycle(a, 1'b0, 32'h0);
		d = rdSample;
	endtask : busRd

	// Sends one packet from a definition while the sink stalls one cycle in three.
	task automatic runPacket(input logic [1:0] def, input logic [15:0] len,
			input logic [15:0] key, input logic [15:0] seq, input logic [15:0] tail);
		logic [31:0] t0;
		logic [31:0] t;
		logic [15:0] base;
		logic [15:0] w [$];
		logic        take;
		logic        last;
		logic        adv;
		logic        done;
		logic [15:0] tw;
		int          nAdv;
		busRd(iena_pkg::OFS_TIME, t0);
		base = sampleIn.word;
		done = 1'b0;
		nAdv = 0;
		sampleIn.valid <= 1'b1;
		sampleIn.def   <= def;
		for (int n = 0; n < 300 && !done; n++) begin
			@(negedge mclk);
			take = udpOut.valid && udpReady;
			last = udpOut.last;
			tw   = udpOut.word;
			adv  = sampleReady && sampleIn.valid;
			@(posedge mclk);
			udpReady <= (n % 3 != 1);
			if (take) w.push_back(tw);
			if (adv) begin
				sampleIn.word <= sampleIn.word + 16'h1;
				nAdv++;
			end
			// Valid drops with the last data sample, so the idle state never sees it
			// again and starts an unwanted packet behind the trailer.
			if (sampleIn.valid && nAdv == int'(len) && w.size() > 0)
				sampleIn.valid <= 1'b0;
			if (take && last)
				done = 1'b1;
		end
		if (!done) failWait();
		check("words", 48'(w.size()), 48'(len) + 48'h8);
		check("key", w[0], key);
		check("size", w[1], len);
		check("time high", w[2], 48'h0);
		t = {w[3], w[4]} - t0;
		check("time", 48'(t <= 32'h1), 48'h1);
		check("status", w[5], 48'h0);
		check("seq", w[6], seq);
		for (int i = 0; i < len; i++) begin
			check("data", w[7+i], base + 16'(i));
		end
		check("trailer", w[7+len], tail);
	endtask : runPacket

	// ----------
	// Sequence
	// ----------
	initial begin
		logic [31:0]        v;
		logic signed [31:0] d;
		logic signed [31:0] o;
		numErrors = 0;
		samplesChecked = 0;
		arst_n = 1'b0;
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
		sampleIn = '{1'b0, 2'h0, 16'h0100};
		udpReady = 1'b1;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			gm_u.send(c < 2 ? 8'h02 : 8'h01, 8'(c), 16'h0, 32'h0, 48'h0);
		end
		gm_u.send(8'h01, iena_pkg::CTL_SYNC, 16'h0, 32'h1, 48'h0);
		gm_u.send(8'h02, iena_pkg::CTL_MGMT, 16'h0, 32'h0, 48'h0);
		busRd(iena_pkg::OFS_DROPS, v);
		check("drops", v[15:0], 48'h6);
		check("response", hresp, 48'h0);
		busRd(iena_pkg::OFS_TRAILER, v);
		check("trailer reset", v, 48'hdead);
		busCycle(8'h3c, 1'b1, 32'hffff);
		busRd(8'h3c, v);
		check("unmapped", v, 48'h0);
		busCycle(iena_pkg::OFS_DEF0, 1'b1, {16'h3, 16'h1234});
		busCycle(iena_pkg::OFS_DEF0 + 8'h4, 1'b1, {16'h0, 16'habcd});
		busCycle(iena_pkg::OFS_CTRL, 1'b1, 32'h1);
		runPacket(2'h0, 16'h3, 16'h1234, 16'h0, 16'hdead);
		runPacket(2'h0, 16'h3, 16'h1234, 16'h1, 16'hdead);
		busCycle(iena_pkg::OFS_TRAILER, 1'b1, 32'hbeef);
		runPacket(2'h1, 16'h0, 16'habcd, 16'h0, 16'hbeef);
		runPacket(2'h0, 16'h3, 16'h1234, 16'h2, 16'hbeef);
		busRd(iena_pkg::OFS_TIME, v);
		gm_u.send(8'h01, iena_pkg::CTL_SYNC, 16'h7, 32'h0, 48'h0);
		gm_u.send(8'h02, iena_pkg::CTL_FOLLOW, 16'h7, 32'h0, {16'h0, v} + 48'd1000);
		busCycle(iena_pkg::OFS_CTRL, 1'b1, 32'h3);
		for (int n = 0; n < 100 && gm_u.reqDone !== 1'b1; n++) @(posedge mclk);
		if (gm_u.reqDone !== 1'b1) failWait();
		check("request head", gm_u.reqWord[0], 48'h0101);
		check("request seq", gm_u.reqWord[1], 48'h0);
		check("request pad", {gm_u.reqWord[2], gm_u.reqWord[3]}, 48'h0);
		gm_u.answer();
		v = 32'h0;
		for (int n = 0; n < 20 && v[2] !== 1'b1; n++) busRd(iena_pkg::OFS_STATUS, v);
		check("offset valid", v[2], 48'h1);
		busRd(iena_pkg::OFS_DELAY, d);
		busRd(iena_pkg::OFS_OFFSET, o);
		check("delay less offset", 48'(d - o >= 39 && d - o <= 41), 48'h1);
		check("delay plus offset", 48'(d + o >= -1000 && d + o <= -999), 48'h1);
		reportAndStop();
	end
endmodule : tb_top

//--- verilog/iena_pkg.sv
// Shared constants, types and register map of the telemetry framer and time slave.
package iena_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned TICK_PERIOD_NS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [4:0] TICK_DIV_MAX = 5'(TICK_CYCLES - 1);

	// ------------------------------------------------------------
	// Packet definitions
	// ------------------------------------------------------------
	localparam int unsigned NUM_DEF = 4;
	localparam logic [15:0] TRAILER_RST = 16'hdead;
	localparam logic [15:0] STATUS_RSVD = 16'h0000;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TRAILER = 8'h04;
	localparam logic [7:0] OFS_DEF0 = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_DELAY = 8'h1c;
	localparam logic [7:0] OFS_OFFSET = 8'h20;
	localparam logic [7:0] OFS_TIME = 8'h24;
	localparam logic [7:0] OFS_DROPS = 8'h28;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_DREQ_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b0;

	// ------------------------------------------------------------
	// Time message codes
	// ------------------------------------------------------------
	localparam logic [7:0] MSG_EVENT = 8'h01;
	localparam logic [7:0] MSG_GENERAL = 8'h02;
	localparam logic [7:0] CTL_SYNC = 8'h00;
	localparam logic [7:0] CTL_DREQ = 8'h01;
	localparam logic [7:0] CTL_FOLLOW = 8'h02;
	localparam logic [7:0] CTL_DRESP = 8'h03;
	localparam logic [7:0] CTL_MGMT = 8'h04;
	localparam int unsigned HDR_RSVD_BYTE = 36;
	localparam int unsigned HDR_RSVD_LEN = 4;
	localparam logic [2:0] DREQ_WORDS = 3'd7;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic [1:0]  def;
		logic [15:0] word;
	} sample_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [15:0] word;
	} word16_t;

	typedef struct packed {
		logic                       valid;
		logic [7:0]                 msgType;
		logic [7:0]                 control;
		logic [15:0]                seqId;
		logic [8*HDR_RSVD_LEN-1:0]  rsvd;
		logic [47:0]                ts;
	} ptp_rx_t;

	typedef enum logic [3:0] {
		F_IDLE, F_KEY, F_SIZE, F_T2, F_T1, F_T0, F_STAT, F_SEQ, F_DATA, F_END
	} frame_state_t;

endpackage : iena_pkg

//--- verilog/iena_ptp_framer.sv
// Telemetry packet framer with register bus and time-sync slave message logic.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module iena_ptp_framer (
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire iena_pkg::sample_t  sampleIn,
	output logic                    sampleReady,
	output iena_pkg::word16_t       udpOut,
	input  wire logic               udpReady,
	input  wire iena_pkg::ptp_rx_t  ptpRx,
	output iena_pkg::word16_t       ptpTx,
	input  wire logic               ptpTxReady
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                   wrPend_q;
	logic [7:0]             wrAddr_q;
	logic [31:0]            rdata_q;
	logic                   enable_q;
	logic                   dreqGo_q;
	logic [15:0]            trailer_q;
	logic [15:0]            defKey_q [iena_pkg::NUM_DEF];
	logic [15:0]            defLen_q [iena_pkg::NUM_DEF];
	logic [15:0]            seq_q [iena_pkg::NUM_DEF];
	logic [4:0]             div_q;
	logic [47:0]            time_q;
	iena_pkg::frame_state_t fState_q;
	logic [1:0]             def_q;
	logic [15:0]            key_q;
	logic [15:0]            len_q;
	logic [47:0]            stamp_q;
	logic [15:0]            cnt_q;
	logic                   canLoad;
	logic                   emitValid;
	logic                   emitLast;
	logic [15:0]            emitWord;
	logic                   txBusy_q;
	logic [2:0]             txIdx_q;
	logic [15:0]            txSeq_q;
	logic                   txCan;
	logic [15:0]            txWord;
	logic [47:0]            t1_q;
	logic [47:0]            t2_q;
	logic [47:0]            t3_q;
	logic [47:0]            t4_q;
	logic [15:0]            syncSeq_q;
	logic                   calcGo_q;
	logic                   calcValid_q;
	logic [15:0]            drops_q;
	logic                   rxOk;
	logic signed [47:0]     delay;
	logic signed [47:0]     offset;
	logic                   calcDone;
	logic                   addrPhase;
	logic                   wrDef;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic isDef(input logic [7:0] a);
		isDef = (a >= iena_pkg::OFS_DEF0) && (a < iena_pkg::OFS_STATUS);
	endfunction : isDef

	function automatic logic [1:0] defIdx(input logic [7:0] a);
		logic [7:0] d;
		d = a - iena_pkg::OFS_DEF0;
		defIdx = d[3:2];
	endfunction : defIdx

	// ------------------------------------------------------------
	// Bus slave: zero wait states, always OKAY
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign addrPhase = hsel && htrans[1] && hready;
	assign wrDef = wrPend_q && isDef(wrAddr_q);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPend_q <= addrPhase && hwrite;
			if (addrPhase)
				wrAddr_q <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			rdata_q <= 32'h0000_0000;
			if (isDef({haddr[7:2], 2'b00}))
				rdata_q <= {defLen_q[defIdx(haddr[7:0])], defKey_q[defIdx(haddr[7:0])]};
			else
				case ({haddr[7:2], 2'b00})
					iena_pkg::OFS_CTRL: rdata_q <= {31'h0000_0000, enable_q};
					iena_pkg::OFS_TRAILER: rdata_q <= {16'h0000, trailer_q};
					iena_pkg::OFS_STATUS: rdata_q <= {29'h0000_0000, calcValid_q, txBusy_q,
						fState_q != iena_pkg::F_IDLE};
					iena_pkg::OFS_DELAY: rdata_q <= delay[31:0];
					iena_pkg::OFS_OFFSET: rdata_q <= offset[31:0];
					iena_pkg::OFS_TIME: rdata_q <= time_q[31:0];
					iena_pkg::OFS_DROPS: rdata_q <= {16'h0000, drops_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= iena_pkg::CTRL_EN_RST;
			dreqGo_q <= 1'b0;
			trailer_q <= iena_pkg::TRAILER_RST;
		end else begin
			dreqGo_q <= 1'b0;
			if (wrPend_q && wrAddr_q == iena_pkg::OFS_CTRL) begin
				enable_q <= hwdata[iena_pkg::CTRL_EN_BIT];
				dreqGo_q <= hwdata[iena_pkg::CTRL_DREQ_BIT];
			end
			// One trailer for every definition; read live at each trailer slot.
			if (wrPend_q && wrAddr_q == iena_pkg::OFS_TRAILER)
				trailer_q <= hwdata[15:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < iena_pkg::NUM_DEF; i++) begin
				defKey_q[i] <= 16'h0000;
				defLen_q[i] <= 16'h0000;
			end
		end else if (wrDef) begin
			defKey_q[defIdx(wrAddr_q)] <= hwdata[15:0];
			defLen_q[defIdx(wrAddr_q)] <= hwdata[31:16];
		end
	end

	// ------------------------------------------------------------
	// Microsecond timebase
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= 5'h00;
			time_q <= 48'h0000_0000_0000;
		end else if (div_q == iena_pkg::TICK_DIV_MAX) begin
			div_q <= 5'h00;
			time_q <= time_q + 48'h0000_0000_0001;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Packet framer
	// ------------------------------------------------------------
	assign canLoad = !udpOut.valid || udpReady;
	assign sampleReady = canLoad && sampleIn.valid && fState_q == iena_pkg::F_DATA;

	always_comb begin
		emitValid = 1'b1;
		emitLast = 1'b0;
		emitWord = 16'h0000;
		case (fState_q)
			iena_pkg::F_KEY: emitWord = key_q;
			iena_pkg::F_SIZE: emitWord = len_q;
			iena_pkg::F_T2: emitWord = stamp_q[47:32];
			iena_pkg::F_T1: emitWord = stamp_q[31:16];
			iena_pkg::F_T0: emitWord = stamp_q[15:0];
			iena_pkg::F_STAT: emitWord = iena_pkg::STATUS_RSVD;
			iena_pkg::F_SEQ: emitWord = seq_q[def_q];
			iena_pkg::F_DATA: begin
				emitWord = sampleIn.word;
				emitValid = sampleIn.valid;
			end
			iena_pkg::F_END: begin
				emitWord = trailer_q;
				emitLast = 1'b1;
			end
			default: emitValid = 1'b0;
		endcase
	end

	// Key and size are snapshotted so a definition rewrite cannot change them mid-packet.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fState_q <= iena_pkg::F_IDLE;
			def_q <= 2'b00;
			key_q <= 16'h0000;
			len_q <= 16'h0000;
			stamp_q <= 48'h0000_0000_0000;
			cnt_q <= 16'h0000;
		end else begin
			case (fState_q)
				iena_pkg::F_IDLE:
					if (enable_q && sampleIn.valid) begin
						def_q <= sampleIn.def;
						key_q <= defKey_q[sampleIn.def];
						len_q <= defLen_q[sampleIn.def];
						stamp_q <= time_q;
						cnt_q <= 16'h0000;
						fState_q <= iena_pkg::F_KEY;
					end
				iena_pkg::F_KEY: if (canLoad) fState_q <= iena_pkg::F_SIZE;
				iena_pkg::F_SIZE: if (canLoad) fState_q <= iena_pkg::F_T2;
				iena_pkg::F_T2: if (canLoad) fState_q <= iena_pkg::F_T1;
				iena_pkg::F_T1: if (canLoad) fState_q <= iena_pkg::F_T0;
				iena_pkg::F_T0: if (canLoad) fState_q <= iena_pkg::F_STAT;
				iena_pkg::F_STAT: if (canLoad) fState_q <= iena_pkg::F_SEQ;
				iena_pkg::F_SEQ:
					if (canLoad)
						fState_q <= (len_q == 16'h0000) ? iena_pkg::F_END : iena_pkg::F_DATA;
				iena_pkg::F_DATA:
					if (canLoad && sampleIn.valid) begin
						cnt_q <= cnt_q + 16'h0001;
						if (cnt_q == len_q - 16'h0001)
							fState_q <= iena_pkg::F_END;
					end
				iena_pkg::F_END: if (canLoad) fState_q <= iena_pkg::F_IDLE;
				default: fState_q <= iena_pkg::F_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < iena_pkg::NUM_DEF; i++)
				seq_q[i] <= 16'h0000;
		end else if (fState_q == iena_pkg::F_END && canLoad) begin
			seq_q[def_q] <= seq_q[def_q] + 16'h0001;
		end else if (wrDef) begin
			seq_q[defIdx(wrAddr_q)] <= 16'h0000;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			udpOut <= '0;
		end else if (canLoad) begin
			udpOut.valid <= emitValid;
			udpOut.last <= emitLast;
			udpOut.word <= emitWord;
		end
	end

	// ------------------------------------------------------------
	// Delay request transmitter
	// ------------------------------------------------------------
	assign txCan = !ptpTx.valid || ptpTxReady;

	always_comb begin
		case (txIdx_q)
			3'd0: txWord = {iena_pkg::MSG_EVENT, iena_pkg::CTL_DREQ};
			3'd1: txWord = txSeq_q;
			3'd4: txWord = t3_q[47:32];
			3'd5: txWord = t3_q[31:16];
			3'd6: txWord = t3_q[15:0];
			default: txWord = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txBusy_q <= 1'b0;
			txIdx_q <= 3'd0;
			txSeq_q <= 16'h0000;
			t3_q <= 48'h0000_0000_0000;
			ptpTx <= '0;
		end else begin
			if (txCan) begin
				ptpTx.valid <= txBusy_q;
				ptpTx.last <= txIdx_q == iena_pkg::DREQ_WORDS - 3'd1;
				ptpTx.word <= txWord;
			end
			if (!txBusy_q && dreqGo_q) begin
				txBusy_q <= 1'b1;
				txIdx_q <= 3'd0;
				t3_q <= time_q;
			end else if (txBusy_q && txCan) begin
				txIdx_q <= txIdx_q + 3'd1;
				if (txIdx_q == iena_pkg::DREQ_WORDS - 3'd1) begin
					txBusy_q <= 1'b0;
					txSeq_q <= txSeq_q + 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Received time messages
	// ------------------------------------------------------------
	assign rxOk = ptpRx.valid && ptpRx.rsvd == '0 &&
		ptpRx.msgType == (ptpRx.control == iena_pkg::CTL_SYNC ||
		ptpRx.control == iena_pkg::CTL_DREQ ? iena_pkg::MSG_EVENT : iena_pkg::MSG_GENERAL);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t1_q <= 48'h0000_0000_0000;
			t2_q <= 48'h0000_0000_0000;
			t4_q <= 48'h0000_0000_0000;
			syncSeq_q <= 16'h0000;
			calcGo_q <= 1'b0;
			drops_q <= 16'h0000;
		end else begin
			calcGo_q <= 1'b0;
			if (ptpRx.valid && !rxOk)
				drops_q <= drops_q + 16'h0001;
			if (rxOk)
				case (ptpRx.control)
					iena_pkg::CTL_SYNC: begin
						t1_q <= ptpRx.ts;
						t2_q <= time_q;
						syncSeq_q <= ptpRx.seqId;
					end
					iena_pkg::CTL_FOLLOW:
						if (ptpRx.seqId == syncSeq_q)
							t1_q <= ptpRx.ts;
					iena_pkg::CTL_DRESP:
						if (ptpRx.seqId == txSeq_q - 16'h0001) begin
							t4_q <= ptpRx.ts;
							calcGo_q <= 1'b1;
						end
					default: ;
				endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			calcValid_q <= 1'b0;
		else if (calcDone)
			calcValid_q <= 1'b1;
	end

	ptp_offset_calc offsetCalc (
		.mclk   (mclk),
		.arst_n (arst_n),
		.start  (calcGo_q),
		.t1     (t1_q),
		.t2     (t2_q),
		.t3     (t3_q),
		.t4     (t4_q),
		.delay  (delay),
		.offset (offset),
		.done   (calcDone)
	);
endmodule : iena_ptp_framer

//--- verilog/ptp_offset_calc.sv
// Path delay and clock offset from one four-timestamp exchange.
`timescale 1ns/1ps
module ptp_offset_calc (
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic               start,
	input  wire logic [47:0]        t1,
	input  wire logic [47:0]        t2,
	input  wire logic [47:0]        t3,
	input  wire logic [47:0]        t4,
	output logic signed [47:0]      delay,
	output logic signed [47:0]      offset,
	output logic                    done
);
	logic signed [47:0] fwd;
	logic signed [47:0] back;
	logic signed [48:0] sum;
	logic signed [47:0] half;

	// Symmetric path: delay is half the round trip without the slave's dwell.
	assign fwd = t2 - t1;
	assign back = t4 - t3;
	assign sum = {fwd[47], fwd} + {back[47], back};
	assign half = sum[48:1];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			delay <= '0;
			offset <= '0;
			done <= 1'b0;
		end else begin
			done <= start;
			if (start) begin
				delay <= half;
				offset <= fwd - half;
			end
		end
	end
endmodule : ptp_offset_calc
